// ==== hdl/crn_pkg.sv ====
// Purpose: Shared constants and types of the card reset and negotiation control.
// Assumes: AXI4-Lite register access with 32-bit data and byte addresses.
// Notes:   Rate factors are carried as their 4-bit index codes.
package crn_pkg;
	localparam int          CRN_AW         = 8;
	localparam int          CRN_ATR_DEPTH  = 16;
	localparam int          CRN_ATR_LEN_W  = 5;
	localparam logic [7:0]  CRN_OFF_CTRL   = 8'h00;
	localparam logic [7:0]  CRN_OFF_STATUS = 8'h04;
	localparam logic [7:0]  CRN_OFF_GLOBAL = 8'h08;
	localparam logic [7:0]  CRN_OFF_PARAM  = 8'h0C;
	localparam logic [7:0]  CRN_OFF_ATRLEN = 8'h10;
	localparam logic [7:0]  CRN_OFF_ATRMEM = 8'h40;
	localparam logic [7:0]  CRN_ATRMEM_END = 8'h7C;
	localparam int          CRN_CTRL_WSPEC = 0;
	localparam int          CRN_CTRL_CLSA  = 1;
	localparam int          CRN_CTRL_NSTOP = 2;
	localparam int          CRN_CTRL_PROTO = 3;
	localparam int          CRN_CTRL_W     = 4;
	localparam int          CRN_GLB_W      = 17;
	localparam int          CRN_GLB_TBPRES = 16;
	localparam int          CRN_TB_B8      = 7;
	localparam int          CRN_TB_B5      = 4;
	localparam logic [3:0]  CRN_PROTO_T15  = 4'hF;
	localparam logic [3:0]  CRN_TD_MIN_IDX = 4'h1;
	localparam logic [3:0]  CRN_FI_DEF     = 4'h1;
	localparam logic [3:0]  CRN_DI_DEF     = 4'h1;
	localparam logic [7:0]  CRN_TB_NONE    = 8'h00;
	localparam logic [1:0]  CRN_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  CRN_RESP_SLVERR = 2'h2;
	localparam int          CRN_CLK_NS     = 5;
	localparam int          CRN_IDLE_NS    = 1000;
	localparam int          CRN_IDLE_CYC   = CRN_IDLE_NS / CRN_CLK_NS;

	typedef enum logic [2:0] {
		CRN_ST_OFF  = 3'b000,
		CRN_ST_RST  = 3'b001,
		CRN_ST_ATR  = 3'b010,
		CRN_ST_NEG  = 3'b011,
		CRN_ST_SPEC = 3'b100
	} crn_state_t;

	typedef struct packed {
		logic       proto_t1;
		logic [3:0] fi;
		logic [3:0] di;
		logic       pps2_en;
		logic [7:0] pps2;
	} crn_pps_req_t;

	typedef struct packed {
		logic       proto_t1;
		logic [3:0] fi;
		logic [3:0] di;
		logic       low_imp;
	} crn_link_par_t;
endpackage

// ==== hdl/crn_ctrl.sv ====
// Purpose: Card side reset classification, answer-to-reset delivery and PPS acceptance.
// Assumes: Pins come from outside the clock domain; PPS requests come from local logic.
// Notes:   The answer-to-reset bytes and global bytes are frozen while contacts are active.
//
// Overview of operation
// - All-zero global TB means no extra parameters.
// - TB b8 and b5 set: low-impedance driver.
// - Global bytes only after TD index>1, T=15.
// - Non-default parameters only after a PPS exchange.
// - Cold reset: negotiable mode, security cleared.
// - Warm reset may keep protocol and rates.
// - Identical answer-to-reset within one session.
// - Every warm reset clears security status.
// - Only first reset after activation is cold.
// - Clock stop forbidden only for class-A-only.
// - Card always does T=0 error repetition.
`timescale 1ns/1ps
module crn_ctrl
	import crn_pkg::*;
#(
	parameter int IDLE_CYC = CRN_IDLE_CYC
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rst_b_i,
	input  wire logic                ce_i,
	input  wire logic                card_clk_i,
	input  wire logic                card_rst_b_i,
	input  wire logic                contact_act_i,
	input  wire logic                s_axi_awvalid_i,
	output logic                     s_axi_awready_o,
	input  wire logic [CRN_AW-1:0]   s_axi_awaddr_i,
	input  wire logic                s_axi_wvalid_i,
	output logic                     s_axi_wready_o,
	input  wire logic [31:0]         s_axi_wdata_i,
	input  wire logic [3:0]          s_axi_wstrb_i,
	output logic                     s_axi_bvalid_o,
	input  wire logic                s_axi_bready_i,
	output logic [1:0]               s_axi_bresp_o,
	input  wire logic                s_axi_arvalid_i,
	output logic                     s_axi_arready_o,
	input  wire logic [CRN_AW-1:0]   s_axi_araddr_i,
	output logic                     s_axi_rvalid_o,
	input  wire logic                s_axi_rready_i,
	output logic [31:0]              s_axi_rdata_o,
	output logic [1:0]               s_axi_rresp_o,
	input  wire logic                pps_valid_i,
	input  wire crn_pps_req_t        pps_req_i,
	input  wire logic                cmd_start_i,
	input  wire logic                sec_set_i,
	input  wire logic                atr_ready_i,
	output logic                     atr_valid_o,
	output logic [7:0]               atr_data_o,
	output logic                     pps_ack_o,
	output logic                     pps_nak_o,
	output crn_link_par_t            link_par_o,
	output logic                     cold_o,
	output logic                     specific_o,
	output logic                     sec_valid_o,
	output logic                     parity_rep_en_o,
	output logic                     clk_stop_ok_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	logic [2:0]                 meta_q;
	logic [2:0]                 sync_q;
	logic                       clk_prev_q;
	logic [15:0]                idle_cnt_q;
	logic                       clk_run_q;
	logic                       aw_have_q;
	logic                       w_have_q;
	logic [CRN_AW-1:0]          awaddr_q;
	logic [31:0]                wdata_q;
	logic [3:0]                 wstrb_q;
	logic [CRN_CTRL_W-1:0]      ctrl_q;
	logic [CRN_GLB_W-1:0]       glb_q;
	logic [CRN_ATR_LEN_W-1:0]   atr_len_q;
	logic [7:0]                 atr_mem [CRN_ATR_DEPTH];
	logic [CRN_ATR_LEN_W-1:0]   atr_idx_q;
	crn_state_t                 st_q;
	crn_link_par_t              par_q;
	logic                       first_q;
	logic                       had_spec_q;
	logic                       wr_go;
	logic                       wr_lock;
	logic                       wr_mapped;
	logic                       atr_we;
	logic [31:0]                wmask;
	logic [31:0]                rd_val;
	logic                       rd_mapped;
	logic                       vcc_s;
	logic                       crst_s;
	logic                       t15_ok;
	logic                       tb_pres;
	logic                       tb_none;
	logic                       tb_lowimp;
	logic                       tb_rfu;
	logic                       atr_done;
	logic                       release_ev;
	logic                       keep_par;

	assign vcc_s  = sync_q[2];
	assign crst_s = sync_q[1];

	// Pins pass two flip-flops before any logic reads them.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else if (ce_i) begin
			meta_q <= {contact_act_i, card_rst_b_i, card_clk_i};
			sync_q <= meta_q;
		end
	end

	// Card clock watchdog: running while an edge was seen within IDLE_CYC cycles.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			clk_prev_q <= 1'b0;
			idle_cnt_q <= '0;
			clk_run_q  <= 1'b0;
		end else if (ce_i) begin
			clk_prev_q <= sync_q[0];
			if (sync_q[0] != clk_prev_q) begin
				idle_cnt_q <= '0;
				clk_run_q  <= 1'b1;
			end else if (idle_cnt_q >= 16'(IDLE_CYC - 1)) begin
				clk_run_q <= 1'b0;
			end else begin
				idle_cnt_q <= idle_cnt_q + 16'h0001;
			end
		end
	end

	assign t15_ok    = (glb_q[3:0] > CRN_TD_MIN_IDX) && (glb_q[7:4] == CRN_PROTO_T15);
	assign tb_pres   = t15_ok && glb_q[CRN_GLB_TBPRES];
	assign tb_none   = tb_pres && (glb_q[15:8] == CRN_TB_NONE);
	assign tb_lowimp = tb_pres && glb_q[8 + CRN_TB_B8] && glb_q[8 + CRN_TB_B5];
	assign tb_rfu    = tb_pres && !tb_none && !tb_lowimp;

	for (genvar b = 0; b < 4; b++) begin : g_mask
		assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
	end

	assign wr_go     = ce_i && aw_have_q && w_have_q && !s_axi_bvalid_o;
	assign wr_mapped = (awaddr_q == CRN_OFF_CTRL) || (awaddr_q == CRN_OFF_GLOBAL) ||
	                   (awaddr_q == CRN_OFF_ATRLEN) ||
	                   ((awaddr_q >= CRN_OFF_ATRMEM) && (awaddr_q <= CRN_ATRMEM_END) &&
	                    (awaddr_q[1:0] == 2'h0));
	assign wr_lock   = vcc_s && (awaddr_q != CRN_OFF_CTRL);
	assign atr_we    = wr_go && wr_mapped && !wr_lock && wstrb_q[0] &&
	                   (awaddr_q >= CRN_OFF_ATRMEM);

	// Write address and data are taken in either order; the response follows both.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_have_q       <= 1'b0;
			w_have_q        <= 1'b0;
			awaddr_q        <= '0;
			wdata_q         <= '0;
			wstrb_q         <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= CRN_RESP_OKAY;
		end else if (ce_i) begin
			s_axi_awready_o <= !aw_have_q && !(s_axi_awvalid_i && s_axi_awready_o);
			s_axi_wready_o  <= !w_have_q && !(s_axi_wvalid_i && s_axi_wready_o);
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata_i;
				wstrb_q  <= s_axi_wstrb_i;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				aw_have_q       <= 1'b0;
				w_have_q        <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end else if (wr_go) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (wr_mapped && !wr_lock) ? CRN_RESP_OKAY : CRN_RESP_SLVERR;
			end
		end
	end

	// Register file. Answer-to-reset content is refused while contacts are active.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q    <= '0;
			glb_q     <= '0;
			atr_len_q <= '0;
		end else if (wr_go && wr_mapped) begin
			if (awaddr_q == CRN_OFF_CTRL) begin
				ctrl_q <= (ctrl_q & wmask[CRN_CTRL_W-1:0]) == ctrl_q ?
				          wdata_q[CRN_CTRL_W-1:0] & wmask[CRN_CTRL_W-1:0] |
				          ctrl_q & ~wmask[CRN_CTRL_W-1:0] :
				          wdata_q[CRN_CTRL_W-1:0] & wmask[CRN_CTRL_W-1:0] |
				          ctrl_q & ~wmask[CRN_CTRL_W-1:0];
			end
			if (!wr_lock && awaddr_q == CRN_OFF_GLOBAL) begin
				glb_q <= (wdata_q[CRN_GLB_W-1:0] & wmask[CRN_GLB_W-1:0]) |
				         (glb_q & ~wmask[CRN_GLB_W-1:0]);
			end
			if (!wr_lock && awaddr_q == CRN_OFF_ATRLEN && wstrb_q[0]) begin
				atr_len_q <= (wdata_q[CRN_ATR_LEN_W-1:0] > CRN_ATR_LEN_W'(CRN_ATR_DEPTH)) ?
				             CRN_ATR_LEN_W'(CRN_ATR_DEPTH) : wdata_q[CRN_ATR_LEN_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (atr_we) begin
			atr_mem[awaddr_q[5:2]] <= wdata_q[7:0];
		end
	end

	property p_atr_lock;
		vcc_s |-> !atr_we;
	endproperty
	a_atr_lock: assert property (p_atr_lock) else $error("ATR content written in session");

	always_comb begin
		rd_val    = '0;
		rd_mapped = 1'b1;
		if (s_axi_araddr_i >= CRN_OFF_ATRMEM && s_axi_araddr_i <= CRN_ATRMEM_END &&
		    s_axi_araddr_i[1:0] == 2'h0) begin
			rd_val = {24'h0000_00, atr_mem[s_axi_araddr_i[5:2]]};
		end else begin
			case (s_axi_araddr_i)
				CRN_OFF_CTRL:   rd_val = 32'(ctrl_q);
				CRN_OFF_STATUS: rd_val = 32'({tb_rfu, tb_lowimp, tb_none, t15_ok,
				                              clk_run_q, sec_valid_o, vcc_s, first_q,
				                              specific_o, cold_o, st_q});
				CRN_OFF_GLOBAL: rd_val = 32'(glb_q);
				CRN_OFF_PARAM:  rd_val = 32'(par_q);
				CRN_OFF_ATRLEN: rd_val = 32'(atr_len_q);
				default:        rd_mapped = 1'b0;
			endcase
		end
	end

	// One read at a time; the answer comes the cycle after the address is taken.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= CRN_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_val;
				s_axi_rresp_o   <= rd_mapped ? CRN_RESP_OKAY : CRN_RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end else if (!s_axi_rvalid_o) begin
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	assign release_ev = vcc_s && crst_s && (st_q == CRN_ST_RST);
	assign keep_par   = !first_q && ctrl_q[CRN_CTRL_WSPEC] && had_spec_q;
	assign atr_done   = (atr_idx_q == atr_len_q) && !atr_valid_o;

	// Reset sequencing and negotiated parameters.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q       <= CRN_ST_OFF;
			first_q    <= 1'b1;
			cold_o     <= 1'b0;
			specific_o <= 1'b0;
			had_spec_q <= 1'b0;
			par_q      <= '0;
			pps_ack_o  <= 1'b0;
			pps_nak_o  <= 1'b0;
		end else if (ce_i) begin
			pps_ack_o <= 1'b0;
			pps_nak_o <= 1'b0;
			if (!vcc_s) begin
				st_q       <= CRN_ST_OFF;
				first_q    <= 1'b1;
				had_spec_q <= 1'b0;
				par_q.low_imp <= 1'b0;
			end else if (!crst_s) begin
				st_q <= CRN_ST_RST;
			end else begin
				case (st_q)
					CRN_ST_RST: begin
						st_q    <= CRN_ST_ATR;
						first_q <= 1'b0;
						cold_o  <= first_q;
						specific_o <= keep_par;
						if (keep_par) begin
							par_q.low_imp <= 1'b0;
						end else begin
							par_q <= '{proto_t1: ctrl_q[CRN_CTRL_PROTO], fi: CRN_FI_DEF,
							           di: CRN_DI_DEF, low_imp: 1'b0};
						end
					end
					CRN_ST_ATR: begin
						if (atr_done) begin
							st_q <= specific_o ? CRN_ST_SPEC : CRN_ST_NEG;
						end
					end
					CRN_ST_NEG: begin
						if (pps_valid_i && pps_req_i.pps2_en && !tb_pres) begin
							pps_nak_o <= 1'b1;
						end else if (pps_valid_i) begin
							pps_ack_o  <= 1'b1;
							st_q       <= CRN_ST_SPEC;
							had_spec_q <= 1'b1;
							par_q      <= '{proto_t1: pps_req_i.proto_t1, fi: pps_req_i.fi,
							                di: pps_req_i.di,
							                low_imp: pps_req_i.pps2_en && tb_lowimp &&
							                         pps_req_i.pps2[CRN_TB_B8] &&
							                         pps_req_i.pps2[CRN_TB_B5]};
						end else if (cmd_start_i) begin
							st_q       <= CRN_ST_SPEC;
							had_spec_q <= 1'b1;
						end
					end
					CRN_ST_OFF:  st_q <= CRN_ST_RST;
					CRN_ST_SPEC: st_q <= CRN_ST_SPEC;
					default:     st_q <= CRN_ST_OFF;
				endcase
			end
		end
	end

	property p_cold_neg;
		ce_i && release_ev && first_q |=> cold_o && !specific_o;
	endproperty
	a_cold_neg: assert property (p_cold_neg) else $error("Cold reset not negotiable");

	property p_warm_keep;
		ce_i && release_ev && keep_par |=> specific_o && (par_q.fi == $past(par_q.fi)) &&
		                                   (par_q.di == $past(par_q.di));
	endproperty
	a_warm_keep: assert property (p_warm_keep) else $error("Specific mode lost rates");

	property p_cold_first;
		ce_i && release_ev |=> (cold_o == $past(first_q)) && !first_q;
	endproperty
	a_cold_first: assert property (p_cold_first) else $error("Reset class wrong");

	property p_pps_neg;
		pps_ack_o |-> $past(st_q) == CRN_ST_NEG && st_q == CRN_ST_SPEC;
	endproperty
	a_pps_neg: assert property (p_pps_neg) else $error("PPS taken outside negotiation");

	property p_lowimp;
		par_q.low_imp |-> tb_lowimp;
	endproperty
	a_lowimp: assert property (p_lowimp) else $error("Low impedance without TB");

	property p_tb_none;
		tb_none |-> !tb_lowimp && !tb_rfu && tb_pres;
	endproperty
	a_tb_none: assert property (p_tb_none) else $error("All-zero TB misdecoded");

	property p_t15;
		tb_pres |-> glb_q[3:0] > CRN_TD_MIN_IDX;
	endproperty
	a_t15: assert property (p_t15) else $error("Global byte before index two");

	// Answer-to-reset byte stream.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			atr_idx_q   <= '0;
			atr_valid_o <= 1'b0;
			atr_data_o  <= '0;
		end else if (ce_i) begin
			if (st_q != CRN_ST_ATR) begin
				atr_idx_q   <= '0;
				atr_valid_o <= 1'b0;
			end else if (atr_valid_o) begin
				atr_valid_o <= !atr_ready_i;
			end else if (atr_idx_q != atr_len_q) begin
				atr_valid_o <= 1'b1;
				atr_data_o  <= atr_mem[atr_idx_q[3:0]];
				atr_idx_q   <= atr_idx_q + CRN_ATR_LEN_W'(1);
			end
		end
	end

	// Security status, its own clock-stop and parity indications.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sec_valid_o     <= 1'b0;
			parity_rep_en_o <= 1'b0;
			clk_stop_ok_o   <= 1'b0;
		end else if (ce_i) begin
			if (st_q == CRN_ST_RST || st_q == CRN_ST_OFF) begin
				sec_valid_o <= 1'b0;
			end else if (sec_set_i) begin
				sec_valid_o <= 1'b1;
			end
			parity_rep_en_o <= vcc_s && !par_q.proto_t1;
			clk_stop_ok_o <= !(ctrl_q[CRN_CTRL_CLSA] && ctrl_q[CRN_CTRL_NSTOP]);
		end
	end

	property p_sec_clr;
		ce_i && st_q == CRN_ST_RST |=> !sec_valid_o;
	endproperty
	a_sec_clr: assert property (p_sec_clr) else $error("Security kept over reset");

	property p_parity;
		ce_i && vcc_s && !par_q.proto_t1 |=> parity_rep_en_o;
	endproperty
	a_parity: assert property (p_parity) else $error("T=0 repetition disabled");

	property p_clkstop;
		ce_i && !ctrl_q[CRN_CTRL_CLSA] |=> clk_stop_ok_o;
	endproperty
	a_clkstop: assert property (p_clkstop) else $error("Clock stop refused off class A");

	assign link_par_o = par_q;
endmodule

// ==== bench/crn_term_model.sv ====
// Purpose: Terminal model driving the contacts, the card reset and the card clock.
// Assumes: The card clock runs at 48 ns only while the contacts are active and not stopped.
// Notes:   Gaps around clock start and stop are counted in card clock cycles.
`timescale 1ns/1ps
module crn_term_model #(
	parameter int START_GAP = 744,
	parameter int STOP_GAP  = 1860
) (
	input  wire logic clk_sys_i,
	output logic      card_clk_o,
	output logic      card_rst_b_o,
	output logic      contact_act_o
);
	logic run_q = 1'b0;
	int   bad_q = 0;
	initial begin
		card_clk_o    = 1'b0;
		card_rst_b_o  = 1'b0;
		contact_act_o = 1'b0;
	end
	// The clock stands low outside a session.
	always #24 card_clk_o = run_q ? ~card_clk_o : 1'b0;
	task automatic activate();
		@(posedge clk_sys_i);
		contact_act_o <= 1'b1;
		run_q         <= 1'b1;
		repeat (START_GAP) @(posedge card_clk_o);
	endtask
	task automatic card_reset();
		@(posedge clk_sys_i);
		card_rst_b_o <= 1'b0;
		repeat (8) @(posedge card_clk_o);
		@(posedge clk_sys_i);
		card_rst_b_o <= 1'b1;
	endtask
	// Stop only where allowed, after the idle gap.
	task automatic stop_clock(input logic allowed);
		if (allowed) begin
			repeat (STOP_GAP) @(posedge card_clk_o);
			@(posedge clk_sys_i);
			run_q <= 1'b0;
		end
	endtask
	// Restart, then hold off the next command.
	task automatic start_clock();
		@(posedge clk_sys_i);
		run_q <= 1'b1;
		repeat (START_GAP) @(posedge card_clk_o);
	endtask
	// Count faulty answers in a row; reject at three.
	task automatic atr_seen(input int got, input int announced, output logic reject);
		bad_q  = (got < announced) ? bad_q + 1 : 0;
		reject = (bad_q >= 3);
	endtask
	// Contacts, reset and clock drop together.
	task automatic deactivate();
		@(posedge clk_sys_i);
		card_rst_b_o  <= 1'b0;
		run_q         <= 1'b0;
		contact_act_o <= 1'b0;
	endtask
endmodule

// ==== bench/crn_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the card reset and negotiation control.
// Assumes: The terminal model drives the card pins; the bench pulses PPS requests.
// Notes:   Contacts must be off while the answer-to-reset bytes are loaded.
`timescale 1ns/1ps
module crn_ctrl_tb_top;
	import crn_pkg::*;
	typedef struct packed {
		logic [31:0] glb;
		logic [3:0]  mask;
		logic [3:0]  exp;
	} crn_row_t;
	crn_row_t rows [8] = '{'{32'h0001_00F2, 4'hF, 4'h3}, '{32'h0001_90F2, 4'hF, 4'h5},
		'{32'h0001_FFF2, 4'hF, 4'h5}, '{32'h0001_80F2, 4'hF, 4'h9},
		'{32'h0001_10F2, 4'hF, 4'h9}, '{32'h0001_01F2, 4'hF, 4'h9},
		'{32'h0001_00F1, 4'h1, 4'h0}, '{32'h0001_00E3, 4'h1, 4'h0}};
	logic [7:0]    atr_exp [3] = '{8'h3B, 8'h10, 8'h97};
	logic [7:0]    atr_q [$];
	logic          clk_sys_i = 1'b0, rst_b_i = 1'b0;
	logic          card_clk, card_rst_b, contact_act;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid, atr_valid, pps_ack, pps_nak;
	logic [7:0]    awaddr = 8'h00, araddr = 8'h00, atr_data;
	logic [31:0]   wdata = 32'h0000_0000, rdata, rdat;
	logic [1:0]    bresp, rresp, resp;
	logic          pps_valid = 1'b0, sec_set = 1'b0, atr_ready = 1'b0, ack, nak, rej;
	crn_pps_req_t  pps_req = '0;
	crn_link_par_t link_par;
	logic          cold, specific, sec_valid, par_rep, stop_ok;
	int            fail_count = 0, total_checks = 0;
	always #2.5 clk_sys_i = ~clk_sys_i;
	crn_term_model u_term (.clk_sys_i(clk_sys_i), .card_clk_o(card_clk),
		.card_rst_b_o(card_rst_b), .contact_act_o(contact_act));
	crn_ctrl #(.IDLE_CYC(20)) u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.card_clk_i(card_clk), .card_rst_b_i(card_rst_b), .contact_act_i(contact_act),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .pps_valid_i(pps_valid),
		.pps_req_i(pps_req), .cmd_start_i(1'b0), .sec_set_i(sec_set),
		.atr_ready_i(atr_ready), .atr_valid_o(atr_valid), .atr_data_o(atr_data),
		.pps_ack_o(pps_ack), .pps_nak_o(pps_nak), .link_par_o(link_par), .cold_o(cold),
		.specific_o(specific), .sec_valid_o(sec_valid), .parity_rep_en_o(par_rep),
		.clk_stop_ok_o(stop_ok));
	// The byte sink stalls every other cycle.
	always @(posedge clk_sys_i) begin
		atr_ready <= ~atr_ready;
		if (atr_valid && atr_ready) atr_q.push_back(atr_data);
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 64) fail_count++;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_sys_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n == 64) fail_count++;
	endtask
	task automatic pps(input crn_pps_req_t q, output logic a, output logic k);
		@(posedge clk_sys_i);
		pps_valid <= 1'b1;
		pps_req   <= q;
		@(posedge clk_sys_i);
		pps_valid <= 1'b0;
		a = 1'b0;
		k = 1'b0;
		repeat (3) begin
			@(posedge clk_sys_i);
			a |= pps_ack;
			k |= pps_nak;
		end
	endtask
	task automatic boot(input logic cold_e, input logic spec_e);
		int n;
		atr_q.delete();
		u_term.card_reset();
		for (n = 0; n < 500 && atr_q.size() < 3; n++) @(posedge clk_sys_i);
		repeat (4) @(posedge clk_sys_i);
		chk("atr count", atr_q.size(), 3);
		u_term.atr_seen(atr_q.size(), 3, rej);
		chk("accepted", rej, 1'b0);
		foreach (atr_q[k]) chk("atr byte", atr_q[k], atr_exp[k]);
		chk("cold", cold, cold_e);
		chk("specific", specific, spec_e);
		chk("security", sec_valid, 1'b0);
		chk("repetition", par_rep, 1'b1);
	endtask
	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		chk("reset outputs", {cold, specific, sec_valid, atr_valid, bvalid, rvalid}, 6'h00);
		rst_b_i <= 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			axi_wr(CRN_OFF_GLOBAL, rows[i].glb, resp);
			chk("global write", resp, CRN_RESP_OKAY);
			axi_rd(CRN_OFF_GLOBAL, rdat, resp);
			chk("global read", rdat, rows[i].glb);
			axi_rd(CRN_OFF_STATUS, rdat, resp);
			chk("tb decode", rdat[12:9] & rows[i].mask, rows[i].exp);
		end
		$display("test decode done");
		axi_rd(8'h20, rdat, resp);
		chk("unmapped resp", resp, CRN_RESP_SLVERR);
		chk("unmapped data", rdat, 32'h0000_0000);
		for (int i = 3; i >= 0; i--) begin
			axi_wr(CRN_OFF_CTRL, {i[1:0], 1'b1}, resp);
			repeat (3) @(posedge clk_sys_i);
			chk("clock stop", stop_ok, i != 3);
		end
		$display("test clock stop done");
		axi_wr(CRN_OFF_GLOBAL, 32'h0001_90F2, resp);
		axi_wr(CRN_OFF_ATRLEN, 32'h0000_0003, resp);
		for (int k = 0; k < 3; k++) axi_wr(CRN_OFF_ATRMEM + 8'(k * 4), atr_exp[k], resp);
		u_term.activate();
		boot(1'b1, 1'b0);
		axi_wr(CRN_OFF_GLOBAL, 32'h0001_00F2, resp);
		chk("frozen global", resp, CRN_RESP_SLVERR);
		@(posedge clk_sys_i);
		sec_set <= 1'b1;
		@(posedge clk_sys_i);
		sec_set <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk("security set", sec_valid, 1'b1);
		pps('{1'b0, 4'h9, 4'h7, 1'b1, 8'h90}, ack, nak);
		chk("pps answer", {ack, nak}, 2'b10);
		chk("pps params", link_par, {1'b0, 4'h9, 4'h7, 1'b1});
		$display("test cold session done");
		boot(1'b0, 1'b1);
		chk("kept params", link_par, {1'b0, 4'h9, 4'h7, 1'b0});
		$display("test warm reset done");
		chk("stop allowed", stop_ok, 1'b1);
		u_term.stop_clock(stop_ok);
		repeat (40) @(posedge clk_sys_i);
		axi_rd(CRN_OFF_STATUS, rdat, resp);
		chk("clock idle", rdat[8], 1'b0);
		u_term.start_clock();
		axi_rd(CRN_OFF_STATUS, rdat, resp);
		chk("clock running", rdat[8], 1'b1);
		$display("test session clock stop done");
		u_term.deactivate();
		repeat (4) @(posedge clk_sys_i);
		axi_wr(CRN_OFF_GLOBAL, 32'h0000_00F2, resp);
		chk("global off", resp, CRN_RESP_OKAY);
		u_term.activate();
		boot(1'b1, 1'b0);
		chk("default params", link_par, {1'b0, CRN_FI_DEF, CRN_DI_DEF, 1'b0});
		pps('{1'b0, 4'h9, 4'h7, 1'b1, 8'h90}, ack, nak);
		chk("pps2 refused", {ack, nak}, 2'b01);
		chk("params held", link_par, {1'b0, CRN_FI_DEF, CRN_DI_DEF, 1'b0});
		pps('{1'b0, CRN_FI_DEF, CRN_DI_DEF, 1'b0, 8'h00}, ack, nak);
		chk("fallback answer", {ack, nak}, 2'b10);
		chk("fallback params", link_par, {1'b0, CRN_FI_DEF, CRN_DI_DEF, 1'b0});
		$display("test second session done");
		u_term.deactivate();
		repeat (4) @(posedge clk_sys_i);
		axi_wr(CRN_OFF_ATRLEN, 32'h0000_0002, resp);
		chk("length off", resp, CRN_RESP_OKAY);
		u_term.activate();
		for (int k = 0; k < 3; k++) begin
			atr_q.delete();
			u_term.card_reset();
			repeat (100) @(posedge clk_sys_i);
			u_term.atr_seen(atr_q.size(), 3, rej);
			chk("short atr", atr_q.size(), 2);
			chk("reject", rej, k == 2);
		end
		$display("test faulty answer done");
		wrap_up();
	end
endmodule
